// *** verilog/slave_port_pkg.sv ***
package slave_port_pkg;

  // register offsets (byte addresses)
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_TIMING = 8'h08;
  localparam logic [7:0] OFS_RX_BYTE_HOLD = 8'h0c;
  localparam logic [7:0] OFS_TX_BYTE_HOLD = 8'h10;
  localparam logic [7:0] OFS_CHECKSUM_VALUE = 8'h14;
  localparam logic [7:0] OFS_FLAGS = 8'h18;
  localparam logic [7:0] OFS_IRQ_ENABLE_SET = 8'h1c;
  localparam logic [7:0] OFS_IRQ_ENABLE_CLEAR = 8'h20;
  localparam logic [7:0] OFS_IRQ_MASK_STATE = 8'h24;
  localparam logic [7:0] OFS_FLAG_CLEAR_PORT = 8'h28;

  // flag positions
  localparam int unsigned BIT_RX_WAITING = 0;
  localparam int unsigned BIT_TX_ROOM = 1;
  localparam int unsigned BIT_SLAVE_ON = 2;
  localparam int unsigned BIT_TRANSFER_COMPLETE = 3;
  localparam int unsigned BIT_SENDING_ROLE = 5;
  localparam int unsigned BIT_TX_UNDERRUN = 6;
  localparam int unsigned BIT_RX_OVERRUN = 7;
  localparam int unsigned BIT_NAK = 8;
  localparam int unsigned BIT_BUS_TIMEOUT = 12;
  localparam int unsigned BIT_CRC_CHECK_FAIL = 13;
  localparam int unsigned BIT_MISPLACED_CONDITION = 14;
  localparam int unsigned BIT_HIT_LSB = 16;
  localparam int unsigned BIT_END_CONDITION_SEEN = 21;
  localparam int unsigned BIT_RESTART_SEEN = 22;
  localparam int unsigned BIT_BYTE_DONE = 23;

  localparam logic [31:0] FLAGS_RESET = 32'h0000_0002;
  localparam logic [31:0] STICKY_MASK = 32'h00ff_71c8;
  localparam logic [31:0] IRQ_SOURCE_MASK = 32'h00ff_71cb;

  // control fields
  localparam int unsigned CTRL_SLAVE_ON = 0;
  localparam int unsigned CTRL_SMBUS_ON = 1;
  localparam int unsigned CTRL_OWN_MATCH_ON = 2;
  localparam int unsigned CTRL_GENCALL_ON = 3;
  localparam int unsigned CTRL_STRETCH_ON_BUFFER = 4;
  localparam int unsigned CTRL_ALERT_ON = 8;
  localparam int unsigned CTRL_DEFAULT_ON = 9;
  localparam int unsigned CTRL_HOST_HDR_ON = 10;
  localparam int unsigned CTRL_CRC_ON = 11;
  localparam int unsigned CTRL_DATA_NAK = 12;
  localparam int unsigned CTRL_OWN_ADDR_LSB = 16;
  localparam logic [31:0] CTRL_WRITE_MASK = 32'h007f_1f1f;

  // timing fields
  localparam int unsigned TIM_EXT_LOW_LSB = 0;
  localparam int unsigned TIM_TIMEOUT_LSB = 8;
  localparam int unsigned TIM_PRESCALE_LSB = 28;
  localparam logic [31:0] TIMING_WRITE_MASK = 32'hf000_ffff;

  localparam logic [6:0] ADDR_SMB_DEFAULT = 7'h61;
  localparam logic [6:0] ADDR_HOST_HEADER = 7'h08;
  localparam logic [6:0] ADDR_ALERT_RESP = 7'h0c;
  localparam logic [6:0] ADDR_GENERAL_CALL = 7'h00;
  localparam logic [7:0] CRC_POLY = 8'h07;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;

  typedef enum logic [3:0] {
    PH_IDLE = 4'b0000,
    PH_ADDR = 4'b0001,
    PH_ACK = 4'b0010,
    PH_RX = 4'b0011,
    PH_STORE = 4'b0100,
    PH_LOAD = 4'b0101,
    PH_TX = 4'b0110,
    PH_TX_ACK = 4'b0111,
    PH_SKIP = 4'b1000
  } phase_type;

  typedef struct packed {
    logic scl;
    logic sda;
    logic scl_rise;
    logic scl_fall;
    logic start;
    logic stop;
  } bus_sense_type;

  typedef struct packed {
    logic [1:0] scl_pipe;
    logic [1:0] sda_pipe;
    logic scl_last;
    logic sda_last;
  } sampler_state_type;

  typedef struct packed {
    phase_type phase;
    logic [3:0] bit_cnt;
    logic [7:0] shift;
    logic rw;
    logic addressed;
    logic data_seen;
    logic nak_seen;
    logic [31:0] ctrl;
    logic [31:0] timing;
    logic [7:0] rx_hold;
    logic [7:0] tx_hold;
    logic tx_room;
    logic rx_waiting;
    logic [7:0] crc;
    logic [31:0] flags;
    logic [31:0] irq_mask;
    logic [31:0] rd_data;
    logic sda_oe;
    logic scl_oe;
    logic [16:0] pre_cnt;
    logic [7:0] ext_cnt;
    logic [7:0] low_cnt;
  } core_state_type;

  localparam core_state_type CORE_RESET = '{phase: PH_IDLE, tx_room: 1'b1, default: '0};

endpackage

// *** verilog/line_sampler.sv ***
`timescale 1ns/1ps
module line_sampler (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic scl_in,
  input wire logic sda_in,
  output slave_port_pkg::bus_sense_type sense
);
  slave_port_pkg::sampler_state_type q, d;

  always_comb begin
    d = q;
    d.scl_pipe = {q.scl_pipe[0], scl_in};
    d.sda_pipe = {q.sda_pipe[0], sda_in};
    d.scl_last = q.scl_pipe[1];
    d.sda_last = q.sda_pipe[1];
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      q <= '1;
    end else begin
      q <= d;
    end
  end

  // both lines pass the same pipe, so their relative order is kept
  always_comb begin
    sense.scl = q.scl_pipe[1];
    sense.sda = q.sda_pipe[1];
    sense.scl_rise = q.scl_pipe[1] & ~q.scl_last;
    sense.scl_fall = ~q.scl_pipe[1] & q.scl_last;
    sense.start = q.scl_pipe[1] & q.scl_last & q.sda_last & ~q.sda_pipe[1];
    sense.stop = q.scl_pipe[1] & q.scl_last & ~q.sda_last & q.sda_pipe[1];
  end
endmodule // line_sampler

// *** verilog/crc8_step.sv ***
`timescale 1ns/1ps
module crc8_step (
  input wire logic [7:0] crc_in,
  input wire logic [7:0] byte_in,
  output logic [7:0] crc_out
);
  always_comb begin
    crc_out = crc_in ^ byte_in;
    for (int i = 0; i < 8; i++) begin
      crc_out = crc_out[7] ? ({crc_out[6:0], 1'b0} ^ slave_port_pkg::CRC_POLY)
                           : {crc_out[6:0], 1'b0};
    end
  end
endmodule // crc8_step

// *** verilog/slave_port.sv ***
// The strobed register port was decided locally.
`timescale 1ns/1ps
module slave_port (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire logic scl_in,
  output logic scl_out,
  output logic scl_oe,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  output logic irq
);
  slave_port_pkg::core_state_type q, d;
  slave_port_pkg::bus_sense_type bus;
  logic [7:0] crc_next;
  logic [31:0] flags_view;
  logic [31:0] ev;
  logic [31:0] clr;
  logic [4:0] hits;
  logic stall;
  logic tick;
  logic timeout;
  logic stretch_on;

  function automatic logic [4:0] addr_hits(input logic [7:0] rx, input logic [31:0] ctrl);
    logic [6:0] a;
    logic smb;
    a = rx[7:1];
    smb = ctrl[slave_port_pkg::CTRL_SMBUS_ON];
    addr_hits[4] = smb & ctrl[slave_port_pkg::CTRL_DEFAULT_ON]
                 & (a == slave_port_pkg::ADDR_SMB_DEFAULT);
    addr_hits[3] = smb & ctrl[slave_port_pkg::CTRL_HOST_HDR_ON]
                 & (a == slave_port_pkg::ADDR_HOST_HEADER);
    addr_hits[2] = smb & ctrl[slave_port_pkg::CTRL_ALERT_ON]
                 & (a == slave_port_pkg::ADDR_ALERT_RESP);
    addr_hits[1] = ctrl[slave_port_pkg::CTRL_GENCALL_ON] & ~rx[0]
                 & (a == slave_port_pkg::ADDR_GENERAL_CALL);
    addr_hits[0] = ctrl[slave_port_pkg::CTRL_OWN_MATCH_ON]
                 & (a == ctrl[slave_port_pkg::CTRL_OWN_ADDR_LSB +: 7]);
  endfunction

  function automatic logic mid_byte(input slave_port_pkg::core_state_type s);
    // a legal start or stop follows the first rise of a byte, so count from two
    mid_byte = (s.phase == slave_port_pkg::PH_ADDR || s.phase == slave_port_pkg::PH_RX
                || s.phase == slave_port_pkg::PH_TX) && (s.bit_cnt > 4'h1);
  endfunction

  function automatic logic limit_hit(input logic [7:0] cnt, input logic [7:0] limit);
    limit_hit = (limit != 8'h00) && (cnt >= limit);
  endfunction

  line_sampler sampler (
    .clock(clock),
    .rst_b(rst_b),
    .scl_in(scl_in),
    .sda_in(sda_in),
    .sense(bus)
  );

  crc8_step crc_unit (
    .crc_in(q.crc),
    .byte_in(q.shift),
    .crc_out(crc_next)
  );

  always_comb begin
    flags_view = q.flags;
    flags_view[slave_port_pkg::BIT_SENDING_ROLE] = q.addressed & q.rw;
    flags_view[slave_port_pkg::BIT_SLAVE_ON] = q.ctrl[slave_port_pkg::CTRL_SLAVE_ON];
    flags_view[slave_port_pkg::BIT_TX_ROOM] = q.tx_room;
    flags_view[slave_port_pkg::BIT_RX_WAITING] = q.rx_waiting;
  end

  always_comb begin
    d = q;
    ev = '0;
    clr = '0;
    hits = '0;
    stall = 1'b0;
    d.rd_data = '0;
    stretch_on = q.ctrl[slave_port_pkg::CTRL_STRETCH_ON_BUFFER];

    tick = (q.pre_cnt >= 17'((17'h1 << (q.timing[slave_port_pkg::TIM_PRESCALE_LSB +: 4] + 1))
                             - 17'h1));
    d.pre_cnt = tick ? 17'h0 : q.pre_cnt + 17'h1;
    if (q.phase == slave_port_pkg::PH_IDLE || q.phase == slave_port_pkg::PH_SKIP) begin
      d.ext_cnt = 8'h00;
      d.low_cnt = 8'h00;
    end else begin
      if (tick && q.scl_oe && q.ext_cnt != 8'hff) begin
        d.ext_cnt = q.ext_cnt + 8'h01;
      end
      if (bus.scl) begin
        d.low_cnt = 8'h00;
      end else if (tick && q.low_cnt != 8'hff) begin
        d.low_cnt = q.low_cnt + 8'h01;
      end
    end
    timeout = (q.phase != slave_port_pkg::PH_IDLE) && (q.phase != slave_port_pkg::PH_SKIP)
              && (limit_hit(q.ext_cnt, q.timing[slave_port_pkg::TIM_EXT_LOW_LSB +: 8])
                  || limit_hit(q.low_cnt, q.timing[slave_port_pkg::TIM_TIMEOUT_LSB +: 8]));

    // register reads, data the cycle after the strobe
    if (reg_rd) begin
      unique case (reg_addr)
        slave_port_pkg::OFS_CTRL: d.rd_data = q.ctrl;
        slave_port_pkg::OFS_TIMING: d.rd_data = q.timing;
        slave_port_pkg::OFS_RX_BYTE_HOLD: begin
          d.rd_data = {24'h00_0000, q.rx_hold};
          d.rx_waiting = 1'b0;
        end
        slave_port_pkg::OFS_CHECKSUM_VALUE: d.rd_data = {24'h00_0000, q.crc};
        slave_port_pkg::OFS_FLAGS: d.rd_data = flags_view;
        slave_port_pkg::OFS_IRQ_MASK_STATE: d.rd_data = q.irq_mask;
        default: d.rd_data = '0;
      endcase
    end

    // protocol engine
    if (!q.ctrl[slave_port_pkg::CTRL_SLAVE_ON]) begin
      d.phase = slave_port_pkg::PH_IDLE;
      d.addressed = 1'b0;
      d.data_seen = 1'b0;
      d.sda_oe = 1'b0;
    end else if (bus.stop) begin
      if (q.addressed) begin
        ev[slave_port_pkg::BIT_END_CONDITION_SEEN] = 1'b1;
        ev[slave_port_pkg::BIT_TRANSFER_COMPLETE] = 1'b1;
        ev[slave_port_pkg::BIT_CRC_CHECK_FAIL] = q.ctrl[slave_port_pkg::CTRL_CRC_ON]
          & q.ctrl[slave_port_pkg::CTRL_SMBUS_ON] & ~q.rw & q.data_seen & (q.crc != 8'h00);
      end
      ev[slave_port_pkg::BIT_MISPLACED_CONDITION] = mid_byte(q);
      d.crc = 8'h00;
      d.phase = slave_port_pkg::PH_IDLE;
      d.addressed = 1'b0;
      d.data_seen = 1'b0;
      d.sda_oe = 1'b0;
    end else if (bus.start) begin
      ev[slave_port_pkg::BIT_RESTART_SEEN] = q.addressed;
      ev[slave_port_pkg::BIT_MISPLACED_CONDITION] = mid_byte(q);
      d.phase = slave_port_pkg::PH_ADDR;
      d.bit_cnt = 4'h0;
      d.addressed = 1'b0;
      d.sda_oe = 1'b0;
    end else if (timeout) begin
      ev[slave_port_pkg::BIT_BUS_TIMEOUT] = 1'b1;
      d.phase = slave_port_pkg::PH_SKIP;
      d.sda_oe = 1'b0;
    end else begin
      unique case (q.phase)
        slave_port_pkg::PH_IDLE, slave_port_pkg::PH_SKIP: begin
        end
        slave_port_pkg::PH_ADDR, slave_port_pkg::PH_RX: begin
          if (bus.scl_rise) begin
            d.shift = {q.shift[6:0], bus.sda};
            d.bit_cnt = q.bit_cnt + 4'h1;
          end else if (bus.scl_fall && q.bit_cnt == slave_port_pkg::BITS_PER_BYTE) begin
            if (q.phase == slave_port_pkg::PH_RX) begin
              d.phase = slave_port_pkg::PH_STORE;
            end else begin
              hits = addr_hits(q.shift, q.ctrl);
              if (|hits) begin
                ev[slave_port_pkg::BIT_HIT_LSB +: 5] = hits;
                d.addressed = 1'b1;
                d.rw = q.shift[0];
                d.sda_oe = 1'b1;
                d.crc = crc_next;
                d.phase = slave_port_pkg::PH_ACK;
              end else begin
                d.phase = slave_port_pkg::PH_SKIP;
              end
            end
          end
        end
        slave_port_pkg::PH_STORE: begin
          if (stretch_on && d.rx_waiting) begin
            stall = 1'b1;
          end else begin
            stall = q.scl_oe;
            ev[slave_port_pkg::BIT_RX_OVERRUN] = d.rx_waiting;
            d.rx_hold = q.shift;
            d.rx_waiting = 1'b1;
            ev[slave_port_pkg::BIT_BYTE_DONE] = 1'b1;
            d.crc = crc_next;
            d.data_seen = 1'b1;
            d.sda_oe = ~q.ctrl[slave_port_pkg::CTRL_DATA_NAK];
            d.phase = slave_port_pkg::PH_ACK;
          end
        end
        slave_port_pkg::PH_ACK: begin
          if (bus.scl_fall) begin
            d.sda_oe = 1'b0;
            d.bit_cnt = 4'h0;
            d.phase = q.rw ? slave_port_pkg::PH_LOAD : slave_port_pkg::PH_RX;
          end
        end
        slave_port_pkg::PH_LOAD: begin
          if (stretch_on && q.tx_room) begin
            stall = 1'b1;
          end else begin
            stall = q.scl_oe;
            ev[slave_port_pkg::BIT_TX_UNDERRUN] = q.tx_room;
            d.shift = q.tx_hold;
            d.tx_room = 1'b1;
            d.sda_oe = ~q.tx_hold[7];
            d.bit_cnt = 4'h0;
            d.phase = slave_port_pkg::PH_TX;
          end
        end
        slave_port_pkg::PH_TX: begin
          if (bus.scl_rise) begin
            d.bit_cnt = q.bit_cnt + 4'h1;
          end else if (bus.scl_fall && q.bit_cnt == slave_port_pkg::BITS_PER_BYTE) begin
            d.sda_oe = 1'b0;
            ev[slave_port_pkg::BIT_BYTE_DONE] = 1'b1;
            d.crc = crc_next;
            d.data_seen = 1'b1;
            d.phase = slave_port_pkg::PH_TX_ACK;
          end else if (bus.scl_fall && q.bit_cnt != 4'h0) begin
            d.sda_oe = ~q.shift[3'(4'h7 - q.bit_cnt)];
          end
        end
        slave_port_pkg::PH_TX_ACK: begin
          if (bus.scl_rise) begin
            d.nak_seen = bus.sda;
          end else if (bus.scl_fall) begin
            ev[slave_port_pkg::BIT_NAK] = q.nak_seen;
            d.phase = q.nak_seen ? slave_port_pkg::PH_SKIP : slave_port_pkg::PH_LOAD;
          end
        end
        default: d.phase = slave_port_pkg::PH_IDLE;
      endcase
    end
    d.scl_oe = stall;

    // register writes come after the engine so a fresh write beats it, but a new event beats a flag clear
    if (reg_wr) begin
      unique case (reg_addr)
        slave_port_pkg::OFS_CTRL: d.ctrl = reg_wdata & slave_port_pkg::CTRL_WRITE_MASK;
        slave_port_pkg::OFS_TIMING: d.timing = reg_wdata & slave_port_pkg::TIMING_WRITE_MASK;
        slave_port_pkg::OFS_TX_BYTE_HOLD: begin
          d.tx_hold = reg_wdata[7:0];
          d.tx_room = 1'b0;
        end
        slave_port_pkg::OFS_IRQ_ENABLE_SET:
          d.irq_mask = q.irq_mask | (reg_wdata & slave_port_pkg::IRQ_SOURCE_MASK);
        slave_port_pkg::OFS_IRQ_ENABLE_CLEAR:
          d.irq_mask = q.irq_mask & ~reg_wdata;
        slave_port_pkg::OFS_FLAG_CLEAR_PORT: clr = reg_wdata & slave_port_pkg::STICKY_MASK;
        default: begin
        end
      endcase
    end

    // sticky, a new event beats a clear
    d.flags = ((q.flags & ~clr) | ev) & slave_port_pkg::STICKY_MASK;
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      q <= slave_port_pkg::CORE_RESET;
    end else begin
      q <= d;
    end
  end

  assign reg_rdata = q.rd_data;
  assign scl_out = 1'b0;
  assign sda_out = 1'b0;
  assign scl_oe = q.scl_oe;
  assign sda_oe = q.sda_oe;
  // request while flag and mask meet
  assign irq = |(flags_view & q.irq_mask);
endmodule // slave_port

// *** testbench/slave_port_monitor.sv ***
`timescale 1ns/1ps
module slave_port_monitor (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic scl_in,
  input wire logic sda_oe,
  input wire logic irq
);
  logic touched_q;
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_b);
  // mask is all zero until the first set write
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      touched_q <= 1'b0;
    end else if (reg_wr && reg_addr == 8'h1c) begin
      touched_q <= 1'b1;
    end
  end
  a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0000_0000)
    else $error("read data outside read slot");
  a_wo_reads_zero: assert property ($past(reg_rd) &&
      $past(reg_addr) inside {8'h10, 8'h1c, 8'h20, 8'h28} |-> reg_rdata == 32'h0000_0000)
    else $error("write-only register read nonzero");
  a_room_on_write: assert property (reg_wr && reg_addr == 8'h10 ##1
      reg_rd && reg_addr == 8'h18 |=> !reg_rdata[1])
    else $error("tx room still set after write");
  a_clear_flags: assert property (reg_wr && reg_addr == 8'h28 ##1
      reg_rd && reg_addr == 8'h18 |=>
      (reg_rdata & $past(reg_wdata, 2) & slave_port_pkg::STICKY_MASK) == 32'h0000_0000)
    else $error("flag survived clear");
  a_mask_set: assert property (reg_wr && reg_addr == 8'h1c ##1
      reg_rd && reg_addr == 8'h24 |=>
      (~reg_rdata & $past(reg_wdata, 2) & slave_port_pkg::IRQ_SOURCE_MASK) == 32'h0000_0000)
    else $error("mask bit not set");
  a_mask_clear: assert property (reg_wr && reg_addr == 8'h20 ##1
      reg_rd && reg_addr == 8'h24 |=> (reg_rdata & $past(reg_wdata, 2)) == 32'h0000_0000)
    else $error("mask bit not cleared");
  a_mask_bits: assert property ($past(reg_rd) && $past(reg_addr) == 8'h24 |->
      (reg_rdata & ~slave_port_pkg::IRQ_SOURCE_MASK) == 32'h0000_0000)
    else $error("mask shows a non-source bit");
  a_irq_quiet: assert property (!touched_q |-> !irq)
    else $error("irq with empty mask");
  a_data_on_low: assert property ($rose(sda_oe) |-> !scl_in && !$past(scl_in, 2))
    else $error("data changed while clock high");
endmodule // slave_port_monitor

bind slave_port slave_port_monitor mon (.clock(clock), .rst_b(rst_b), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .scl_in(scl_in), .sda_oe(sda_oe), .irq(irq));

// *** testbench/bus_master_model.sv ***
`timescale 1ns/1ps
module bus_master_model (
  output logic scl_pull,
  output logic sda_pull,
  input wire logic scl_line,
  input wire logic sda_line
);
  int hang = 0;
  initial begin
    scl_pull = 1'b0;
    sda_pull = 1'b0;
  end
  task clk_high();
    int i;
    scl_pull = 1'b0;
    for (i = 0; i < 20000 && scl_line !== 1'b1; i++) #4;
    if (i == 20000) hang++;
    #80;
  endtask
  task put_bit(input logic b);
    sda_pull = ~b;
    #40 clk_high();
    scl_pull = 1'b1;
    #40;
  endtask
  task get_bit(output logic b);
    sda_pull = 1'b0;
    #40 clk_high();
    b = sda_line;
    scl_pull = 1'b1;
    #40;
  endtask
  task start_c();
    sda_pull = 1'b0;
    #40 scl_pull = 1'b0;
    #80 sda_pull = 1'b1;
    #80 scl_pull = 1'b1;
    #40;
  endtask
  task stop_c();
    sda_pull = 1'b1;
    #40 scl_pull = 1'b0;
    #80 sda_pull = 1'b0;
    #80;
  endtask
  task send(input logic [7:0] d, output logic ack);
    logic a;
    for (int i = 7; i >= 0; i--) put_bit(d[i]);
    get_bit(a);
    ack = ~a;
  endtask
  task recv(output logic [7:0] d, input logic nak);
    for (int i = 7; i >= 0; i--) get_bit(d[i]);
    put_bit(nak);
  endtask
endmodule // bus_master_model

// *** testbench/tb_top.sv ***
`timescale 1ns/1ps
module tb_top;
  logic clock = 1'b0;
  logic rst_b = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0000_0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [31:0] reg_rdata, q, d32, mmask;
  logic scl_out, scl_oe, sda_out, sda_oe, irq, m_scl, m_sda, ack;
  logic [7:0] d, b, crc;
  logic [6:0] own;
  logic [6:0] ha [5];
  logic [7:0] ro [9] = '{8'h0c, 8'h10, 8'h14, 8'h1c, 8'h20, 8'h24, 8'h28, 8'h04, 8'h2c};
  int error_cnt = 0;
  int checks_done = 0;
  wire scl_line = ~(scl_oe & ~scl_out) & ~m_scl;
  wire sda_line = ~(sda_oe & ~sda_out) & ~m_sda;
  always #2 clock = ~clock;
  slave_port uut (.clock(clock), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .scl_in(scl_line),
    .scl_out(scl_out), .scl_oe(scl_oe), .sda_in(sda_line), .sda_out(sda_out),
    .sda_oe(sda_oe), .irq(irq));
  bus_master_model m (.scl_pull(m_scl), .sda_pull(m_sda), .scl_line(scl_line),
    .sda_line(sda_line));
  task chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task results();
    $display("mismatches=%0d comparisons=%0d", error_cnt, checks_done);
    if (error_cnt == 0 && checks_done > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // a write may run straight into a read with no gap
  task acc(input logic w, input logic [7:0] a, input logic [31:0] dw, input logic r,
      input logic [7:0] ra);
    @(posedge clock);
    if (w) begin
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= dw;
      @(posedge clock);
      reg_wr <= 1'b0;
    end
    if (r) begin
      reg_rd <= 1'b1;
      reg_addr <= ra;
      @(posedge clock);
      reg_rd <= 1'b0;
      #1 q = reg_rdata;
    end
  endtask
  task wr(input logic [7:0] a, input logic [31:0] dw);
    acc(1'b1, a, dw, 1'b0, 8'h00);
  endtask
  task rd(input logic [7:0] a);
    acc(1'b0, 8'h00, 32'h0000_0000, 1'b1, a);
  endtask
  task flags(input logic [31:0] e);
    rd(8'h18);
    chk(q & slave_port_pkg::STICKY_MASK, e);
    wr(8'h28, 32'hffff_ffff);
  endtask
  function automatic logic [7:0] crc8(input logic [7:0] c, input logic [7:0] v);
    logic [7:0] x;
    x = c ^ v;
    for (int i = 0; i < 8; i++) x = x[7] ? ((x << 1) ^ slave_port_pkg::CRC_POLY) : (x << 1);
    return x;
  endfunction
  initial begin
    #200_000 error_cnt++;
    results();
  end
  initial begin
    void'($urandom(32));
    mmask = 32'h0000_0000;
    repeat (2) @(posedge clock);
    rst_b <= 1'b1;
    rd(8'h18);
    chk(q, slave_port_pkg::FLAGS_RESET);
    foreach (ro[i]) begin
      rd(ro[i]);
      chk(q, 32'h0000_0000);
    end
    acc(1'b1, 8'h18, $urandom, 1'b1, 8'h18);
    chk(q, slave_port_pkg::FLAGS_RESET);
    for (int i = 0; i < 8; i++) begin
      d32 = $urandom;
      if (i % 2 == 1) mmask &= ~d32;
      else mmask |= d32;
      acc(1'b1, (i % 2 == 1) ? 8'h20 : 8'h1c, d32, 1'b1, 8'h24);
      chk(q, mmask & slave_port_pkg::IRQ_SOURCE_MASK);
    end
    acc(1'b1, 8'h20, 32'hffff_ffff, 1'b1, 8'h24);
    chk(q, 32'h0000_0000);
    acc(1'b1, 8'h1c, 32'h0000_0002, 1'b1, 8'h18);
    chk({31'h0, irq}, 32'h0000_0001);
    acc(1'b1, 8'h20, 32'h0000_0002, 1'b1, 8'h18);
    chk({31'h0, irq}, 32'h0000_0000);
    own = 7'h40 | 7'($urandom % 32);
    ha = '{7'h61, 7'h08, 7'h0c, 7'h00, own};
    wr(8'h00, 32'h0000_0f0f | {9'h0, own, 16'h0});
    rd(8'h18);
    chk(q & 32'h0000_0027, 32'h0000_0006);
    wr(8'h1c, slave_port_pkg::STICKY_MASK);
    for (int i = 0; i < 5; i++) begin
      m.start_c();
      m.send({ha[i], 1'b0}, ack);
      m.stop_c();
      chk({31'h0, ack}, 32'h0000_0001);
      rd(8'h18);
      chk(q & 32'h003f_0008, 32'h0020_0008 | (32'h1 << (20 - i)));
      chk({31'h0, irq}, 32'h0000_0001);
      acc(1'b1, 8'h28, 32'hffff_ffff, 1'b1, 8'h18);
      chk(q & slave_port_pkg::STICKY_MASK, 32'h0000_0000);
      chk({31'h0, irq}, 32'h0000_0000);
    end
    wr(8'h20, 32'hffff_ffff);
    // receive with checksum check, no stretching
    wr(8'h00, 32'h0000_0807 | {9'h0, own, 16'h0});
    crc = crc8(8'h00, {own, 1'b0});
    m.start_c();
    m.send({own, 1'b0}, ack);
    d = 8'($urandom);
    m.send(d, ack);
    crc = crc8(crc, d);
    acc(1'b1, 8'h0c, $urandom, 1'b1, 8'h0c);
    chk(q, {24'h0, d});
    rd(8'h14);
    chk(q, {24'h0, crc});
    rd(8'h18);
    chk(q & 32'h0000_0027, 32'h0000_0006);
    for (int i = 0; i < 2; i++) begin
      d = 8'($urandom);
      m.send(d, ack);
      crc = crc8(crc, d);
    end
    rd(8'h18);
    chk(q & 32'h0000_0081, 32'h0000_0081);
    m.stop_c();
    rd(8'h14);
    chk(q, 32'h0000_0000);
    rd(8'h0c);
    chk(q, {24'h0, d});
    flags(32'h00a1_0088 | ((crc != 8'h00) ? 32'h0000_2000 : 32'h0000_0000));
    // send one buffered byte, then one from an empty buffer, no stretching
    wr(8'h00, 32'h0000_0005 | {9'h0, own, 16'h0});
    d = 8'($urandom);
    acc(1'b1, 8'h10, {24'h0, d}, 1'b1, 8'h18);
    chk(q & 32'h0000_0002, 32'h0000_0000);
    m.start_c();
    m.send({own, 1'b1}, ack);
    rd(8'h18);
    chk(q & 32'h0000_0022, 32'h0000_0022);
    m.recv(b, 1'b0);
    chk({24'h0, b}, {24'h0, d});
    m.recv(b, 1'b1);
    chk({24'h0, b}, {24'h0, d});
    m.stop_c();
    flags(32'h00a1_0148);
    // stretched send after a repeated start
    wr(8'h00, 32'h0000_0015 | {9'h0, own, 16'h0});
    m.start_c();
    m.send({own, 1'b0}, ack);
    m.start_c();
    m.send({own, 1'b1}, ack);
    d = 8'($urandom);
    fork
      m.recv(b, 1'b1);
      begin
        for (int n = 0; n < 400 && scl_oe !== 1'b1; n++) @(posedge clock);
        chk({31'h0, scl_oe}, 32'h0000_0001);
        wr(8'h10, {24'h0, d});
      end
    join
    chk({24'h0, b}, {24'h0, d});
    m.stop_c();
    flags(32'h00e1_0108);
    // stretch runs past the extension limit, then a stop inside a byte
    wr(8'h08, 32'h0000_0004);
    m.start_c();
    m.send({own, 1'b1}, ack);
    m.recv(b, 1'b1);
    m.stop_c();
    rd(8'h18);
    chk(q & 32'h0000_1000, 32'h0000_1000);
    wr(8'h08, 32'h0000_0000);
    wr(8'h28, 32'hffff_ffff);
    m.start_c();
    m.send({own, 1'b0}, ack);
    m.put_bit(1'b1);
    m.put_bit(1'b0);
    m.stop_c();
    rd(8'h18);
    chk(q & 32'h0000_4000, 32'h0000_4000);
    // data-phase refusal still stores the byte
    wr(8'h00, 32'h0000_1005 | {9'h0, own, 16'h0});
    m.start_c();
    m.send({own, 1'b0}, ack);
    d = 8'($urandom);
    m.send(d, ack);
    m.stop_c();
    chk({31'h0, ack}, 32'h0000_0000);
    rd(8'h0c);
    chk(q, {24'h0, d});
    chk({30'h0, scl_out, sda_out}, 32'h0000_0000);
    wr(8'h00, 32'h0000_0000);
    rd(8'h18);
    chk(q & 32'h0000_0004, 32'h0000_0000);
    chk(m.hang, 32'h0000_0000);
    results();
  end
endmodule // tb_top
